/* rtl/fpet_cfg.svh */
// Purpose: Constants for the flash program and erase timer.
// Assumes: System clock of 10 MHz.
// Notes: Widths follow the count registers of the timing block.
`ifndef FPET_CFG_SVH
`define FPET_CFG_SVH
`define FPET_PSC_W 8
`define FPET_CNT_W 8
// One spare bit, so that an erase count of 255 does not wrap the interval to zero.
`define FPET_BIG_W 21
`define FPET_MUL_PROG 21'h000008
`define FPET_MUL_PAGE 21'h001000
`define FPET_MUL_BULK 21'h001000
`define FPET_MUL_BHOLD 21'h000008
`define FPET_MUL_ONE 21'h000001
`define FPET_BIG_ONE 21'h000001
`define FPET_OP_CODE_PROG 2'h0
`define FPET_OP_CODE_PAGE 2'h1
`define FPET_OP_CODE_BULK 2'h2
`define FPET_OP_CODE_NONE 2'h3
`define FPET_PSC_ZERO 8'h00
`define FPET_PSC_ONE 8'h01
`endif

/* rtl/fpet_pkg.sv */
// Purpose: Types for the flash program and erase timer.
// Assumes: Constants come from fpet_cfg.svh.
// Notes: None.
package fpet_pkg;
    typedef enum logic [2:0] {
        FPET_IDLE,
        FPET_SETUP,
        FPET_TRAN,
        FPET_PULSE,
        FPET_HOLD,
        FPET_RECOVER
    } fpet_state_t;

    typedef enum logic [1:0] {
        FPET_OP_PROG,
        FPET_OP_PAGE,
        FPET_OP_BULK
    } fpet_op_t;
endpackage : fpet_pkg

/* rtl/fpet_tick.sv */
// Purpose: Prescaler that gives one tick every prescale plus one clocks.
// Assumes: Prescale value is stable while the timer runs.
// Notes: Restart forces the count back so each interval starts aligned.
`timescale 1ns/1ps
`default_nettype none
`include "fpet_cfg.svh"
module fpet_tick (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic [`FPET_PSC_W-1:0] prescale,
    output logic tick
);
    typedef struct packed {
        logic [`FPET_PSC_W-1:0] cnt;
    } fpet_tick_st_t;

    fpet_tick_st_t st_reg;
    fpet_tick_st_t st_next;

    always_comb
    begin
        st_next = st_reg;
        tick = 1'b0;
        if (restart)
        begin
            st_next.cnt = `FPET_PSC_ZERO;
        end
        else if (st_reg.cnt == prescale)
        begin
            st_next.cnt = `FPET_PSC_ZERO;
            tick = 1'b1;
        end
        else
        begin
            st_next.cnt = st_reg.cnt + `FPET_PSC_ONE;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end
endmodule : fpet_tick
`default_nettype wire

/* rtl/fpet_timer.sv */
// Purpose: Sequences program and erase controls of the flash array.
// Assumes: Software keeps the count values within the array limits.
// Notes: Every interval is (prescale+1) x multiplier x (count+1) clocks.
// Overview of operation
// - Setup gap before strobe uses setup count.
// - Strobe to pulse gap uses transition count.
// - Program pulse spans eight times program count.
// - Page erase pulse spans 4096 times count.
// - Bulk erase pulse spans 4096 times count.
// - Strobe hold after program or page erase.
// - Strobe hold after bulk erase, eight times.
// - Recovery interval before array reuse.
// - Prescale chosen by selected array.
`timescale 1ns/1ps
`default_nettype none
`include "fpet_cfg.svh"
module fpet_timer (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic START,
    input wire logic [1:0] OP_SEL,
    input wire logic DATA_ARRAY_SEL,
    input wire logic [`FPET_PSC_W-1:0] CODE_ARRAY_PRESCALER,
    input wire logic [`FPET_PSC_W-1:0] DATA_ARRAY_PRESCALER,
    input wire logic [`FPET_CNT_W-1:0] SETUP_DELAY_COUNT,
    input wire logic [`FPET_CNT_W-1:0] TRANSITION_DELAY_COUNT,
    input wire logic [`FPET_CNT_W-1:0] PROGRAM_PULSE_COUNT,
    input wire logic [`FPET_CNT_W-1:0] PAGE_ERASE_COUNT,
    input wire logic [`FPET_CNT_W-1:0] BULK_ERASE_COUNT,
    input wire logic [`FPET_CNT_W-1:0] STORE_HOLD_COUNT,
    input wire logic [`FPET_CNT_W-1:0] BULK_STORE_HOLD_COUNT,
    input wire logic [`FPET_CNT_W-1:0] RECOVERY_COUNT,
    output logic PROGRAM_EN,
    output logic PAGE_ERASE_EN,
    output logic BULK_ERASE_EN,
    output logic STORAGE_STROBE,
    output logic PULSE_ACTIVE,
    output logic BUSY,
    output logic DONE
);
    typedef struct packed {
        fpet_pkg::fpet_state_t state;
        fpet_pkg::fpet_op_t op;
        logic data_sel;
        logic [`FPET_BIG_W-1:0] ticks;
        logic prog;
        logic page;
        logic bulk;
        logic strobe;
        logic pulse;
        logic done;
    } fpet_st_t;

    fpet_st_t st_reg;
    fpet_st_t st_next;
    logic tick;
    logic restart;
    logic last;
    logic [`FPET_PSC_W-1:0] prescale;
    logic [`FPET_BIG_W-1:0] pulse_len;
    logic [`FPET_BIG_W-1:0] hold_len;
    logic start_ok;
    logic [2:0] mode_sel;

    // Prescaler is latched per operation through the stored array select.
    assign prescale = st_reg.data_sel ? DATA_ARRAY_PRESCALER : CODE_ARRAY_PRESCALER;

    fpet_tick u_tick (
        .clk(CLK),
        .rst_b(RST_B),
        .restart(restart),
        .prescale(prescale),
        .tick(tick)
    );

    // Lengths are in prescaled ticks: multiplier times (count+1).
    function automatic logic [`FPET_BIG_W-1:0] fpet_len(
        input logic [`FPET_BIG_W-1:0] mul,
        input logic [`FPET_CNT_W-1:0] cnt
    );
        logic [2*`FPET_BIG_W-1:0] prod;
        prod = mul * ({{(`FPET_BIG_W-`FPET_CNT_W){1'b0}}, cnt} + `FPET_BIG_ONE);
        return prod[`FPET_BIG_W-1:0];
    endfunction : fpet_len

    always_comb
    begin
        case (st_reg.op)
            fpet_pkg::FPET_OP_PROG: pulse_len = fpet_len(`FPET_MUL_PROG, PROGRAM_PULSE_COUNT);
            fpet_pkg::FPET_OP_PAGE: pulse_len = fpet_len(`FPET_MUL_PAGE, PAGE_ERASE_COUNT);
            default: pulse_len = fpet_len(`FPET_MUL_BULK, BULK_ERASE_COUNT);
        endcase
        if (st_reg.op == fpet_pkg::FPET_OP_BULK)
        begin
            hold_len = fpet_len(`FPET_MUL_BHOLD, BULK_STORE_HOLD_COUNT);
        end
        else
        begin
            hold_len = fpet_len(`FPET_MUL_ONE, STORE_HOLD_COUNT);
        end
    end

    assign last = tick && (st_reg.ticks == `FPET_BIG_ONE);
    assign restart = (st_reg.state == fpet_pkg::FPET_IDLE);

    // The unused op code is dropped here, so a stray request never touches the array.
    assign start_ok = START && (OP_SEL != `FPET_OP_CODE_NONE);

    // One-hot mode lines for the op about to start.
    always_comb
    begin
        if (OP_SEL == `FPET_OP_CODE_PROG)
        begin
            mode_sel = 3'h4;
        end
        else if (OP_SEL == `FPET_OP_CODE_PAGE)
        begin
            mode_sel = 3'h2;
        end
        else if (OP_SEL == `FPET_OP_CODE_BULK)
        begin
            mode_sel = 3'h1;
        end
        else
        begin
            mode_sel = 3'h0;
        end
    end

    // Each phase loads its length on entry and moves on at its last tick.
    always_comb
    begin
        st_next = st_reg;
        st_next.done = 1'b0;
        if (tick && st_reg.state != fpet_pkg::FPET_IDLE)
        begin
            st_next.ticks = st_reg.ticks - `FPET_BIG_ONE;
        end
        case (st_reg.state)
            fpet_pkg::FPET_IDLE:
            begin
                if (start_ok)
                begin
                    st_next.op = fpet_pkg::fpet_op_t'(OP_SEL);
                    st_next.data_sel = DATA_ARRAY_SEL;
                    st_next.prog = mode_sel[2];
                    st_next.page = mode_sel[1];
                    st_next.bulk = mode_sel[0];
                    st_next.ticks = fpet_len(`FPET_MUL_ONE, SETUP_DELAY_COUNT);
                    st_next.state = fpet_pkg::FPET_SETUP;
                end
            end
            fpet_pkg::FPET_SETUP:
            begin
                if (last)
                begin
                    st_next.strobe = 1'b1;
                    st_next.ticks = fpet_len(`FPET_MUL_ONE, TRANSITION_DELAY_COUNT);
                    st_next.state = fpet_pkg::FPET_TRAN;
                end
            end
            fpet_pkg::FPET_TRAN:
            begin
                if (last)
                begin
                    st_next.pulse = 1'b1;
                    st_next.ticks = pulse_len;
                    st_next.state = fpet_pkg::FPET_PULSE;
                end
            end
            fpet_pkg::FPET_PULSE:
            begin
                if (last)
                begin
                    // Mode line drops at pulse end; strobe stays for the hold.
                    st_next.pulse = 1'b0;
                    st_next.prog = 1'b0;
                    st_next.page = 1'b0;
                    st_next.bulk = 1'b0;
                    st_next.ticks = hold_len;
                    st_next.state = fpet_pkg::FPET_HOLD;
                end
            end
            fpet_pkg::FPET_HOLD:
            begin
                if (last)
                begin
                    st_next.strobe = 1'b0;
                    st_next.ticks = fpet_len(`FPET_MUL_ONE, RECOVERY_COUNT);
                    st_next.state = fpet_pkg::FPET_RECOVER;
                end
            end
            fpet_pkg::FPET_RECOVER:
            begin
                if (last)
                begin
                    st_next.done = 1'b1;
                    st_next.state = fpet_pkg::FPET_IDLE;
                end
            end
            default:
            begin
                st_next.state = fpet_pkg::FPET_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign PROGRAM_EN = st_reg.prog;
    assign PAGE_ERASE_EN = st_reg.page;
    assign BULK_ERASE_EN = st_reg.bulk;
    assign STORAGE_STROBE = st_reg.strobe;
    assign PULSE_ACTIVE = st_reg.pulse;
    assign BUSY = (st_reg.state != fpet_pkg::FPET_IDLE);
    assign DONE = st_reg.done;
endmodule : fpet_timer
`default_nettype wire

/* verification/fpet_timer_properties.sv */
// Purpose: Timing checks on the flash program and erase timer.
// Assumes: Ports as declared by fpet_timer.
// Notes: Exact lengths are checked for zero prescale and counts only.
`timescale 1ns/1ps
`default_nettype none
module fpet_timer_properties (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic START,
    input wire logic [1:0] OP_SEL,
    input wire logic [7:0] CODE_ARRAY_PRESCALER,
    input wire logic [7:0] DATA_ARRAY_PRESCALER,
    input wire logic [7:0] SETUP_DELAY_COUNT,
    input wire logic [7:0] PROGRAM_PULSE_COUNT,
    input wire logic PROGRAM_EN,
    input wire logic PAGE_ERASE_EN,
    input wire logic BULK_ERASE_EN,
    input wire logic STORAGE_STROBE,
    input wire logic PULSE_ACTIVE,
    input wire logic BUSY,
    input wire logic DONE
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
    wire logic pz = CODE_ARRAY_PRESCALER == 8'h00 && DATA_ARRAY_PRESCALER == 8'h00;
    wire logic md = PROGRAM_EN | PAGE_ERASE_EN | BULK_ERASE_EN;
    a_start_taken: assert property (!BUSY && START && OP_SEL == 2'h0 |=> BUSY && PROGRAM_EN)
        else $error("Start not taken.");
    a_op_ignored: assert property (!BUSY && START && OP_SEL == 2'h3 |=> !BUSY)
        else $error("Unused op started.");
    a_strobe_order: assert property ($rose(STORAGE_STROBE) |-> md && !PULSE_ACTIVE)
        else $error("Strobe out of order.");
    a_pulse_inside: assert property (PULSE_ACTIVE |-> STORAGE_STROBE && md)
        else $error("Pulse without strobe.");
    a_hold_after: assert property ($fell(PULSE_ACTIVE) |-> STORAGE_STROBE && !md)
        else $error("Strobe not held.");
    a_done_once: assert property ($fell(BUSY) |-> DONE ##1 !DONE)
        else $error("Done not one pulse.");
    a_setup_exact: assert property ($rose(BUSY) && pz && SETUP_DELAY_COUNT == 8'h00
        |-> !STORAGE_STROBE ##1 STORAGE_STROBE) else $error("Setup length wrong.");
    a_prog_exact: assert property ($rose(PULSE_ACTIVE) && PROGRAM_EN && pz
        && PROGRAM_PULSE_COUNT == 8'h00 |-> PULSE_ACTIVE[*8] ##1 !PULSE_ACTIVE)
        else $error("Pulse length wrong.");
    cover property ($rose(PAGE_ERASE_EN));
    cover property ($rose(BULK_ERASE_EN));
    cover property (DONE && START);
endmodule : fpet_timer_properties
bind fpet_timer fpet_timer_properties u_props (.CLK, .RST_B, .START, .OP_SEL,
    .CODE_ARRAY_PRESCALER, .DATA_ARRAY_PRESCALER, .SETUP_DELAY_COUNT, .PROGRAM_PULSE_COUNT,
    .PROGRAM_EN, .PAGE_ERASE_EN, .BULK_ERASE_EN, .STORAGE_STROBE, .PULSE_ACTIVE, .BUSY, .DONE);
`default_nettype wire

/* verification/fpet_flash_model.sv */
// Purpose: Flash array side that measures each control interval.
// Assumes: Controls change only on rising clock edges.
// Notes: Lengths are in clocks, from one control edge to the next.
`timescale 1ns/1ps
`default_nettype none
module fpet_flash_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic strobe,
    input wire logic pulse,
    input wire logic busy,
    output var int len [5],
    output var logic order_bad
);
    logic [2:0] s;
    int c;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s <= 3'h0;
            c <= 0;
            len <= '{default: 0};
            order_bad <= 1'b0;
        end
        else
        begin
            s <= {strobe, pulse, busy};
            c <= ({strobe, pulse, busy} != s) ? 1 : c + 1;
            if (strobe && !s[2]) len[0] <= c;
            if (pulse && !s[1]) len[1] <= c;
            if (!pulse && s[1]) len[2] <= c;
            if (!strobe && s[2]) len[3] <= c;
            if (!busy && s[0]) len[4] <= c;
            // A strobe edge during the pulse or outside a run would stress the array.
            if (strobe != s[2] && (pulse || !busy)) order_bad <= 1'b1;
        end
    end
endmodule : fpet_flash_model
`default_nettype wire

/* verification/fpet_timer_tb_top.sv */
// Purpose: Random and corner runs of the flash program and erase timer.
// Assumes: Small erase counts keep the run short.
// Notes: The array model measures the intervals.
`timescale 1ns/1ps
`default_nettype none
module fpet_timer_tb_top;
    logic clk = 1'b0, rst_b = 1'b0, start = 1'b0, dsel = 1'b0;
    logic [1:0] op = 2'h0;
    logic [7:0] psc [2] = '{8'h00, 8'h00};
    logic [7:0] cnt [8] = '{default: 8'h00};
    logic pe, ge, be, stb, pul, busy, done, bad;
    int len [5];
    int miscompares = 0, samples_checked = 0, seed = 71086;
    initial forever #50 clk = ~clk;
    fpet_timer dut (.CLK(clk), .RST_B(rst_b), .START(start), .OP_SEL(op), .DATA_ARRAY_SEL(dsel),
        .CODE_ARRAY_PRESCALER(psc[0]), .DATA_ARRAY_PRESCALER(psc[1]),
        .SETUP_DELAY_COUNT(cnt[0]), .TRANSITION_DELAY_COUNT(cnt[1]), .PROGRAM_PULSE_COUNT(cnt[2]),
        .PAGE_ERASE_COUNT(cnt[3]), .BULK_ERASE_COUNT(cnt[4]), .STORE_HOLD_COUNT(cnt[5]),
        .BULK_STORE_HOLD_COUNT(cnt[6]), .RECOVERY_COUNT(cnt[7]), .PROGRAM_EN(pe),
        .PAGE_ERASE_EN(ge), .BULK_ERASE_EN(be), .STORAGE_STROBE(stb), .PULSE_ACTIVE(pul),
        .BUSY(busy), .DONE(done));
    fpet_flash_model u_array (.clk(clk), .rst_b(rst_b), .strobe(stb), .pulse(pul),
        .busy(busy), .len(len), .order_bad(bad));
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task results;
        $display("Compared %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    function int exp_len(input int i);
        int t;
        t = psc[dsel] + 1;
        case (i)
            0: return (cnt[0] + 1) * t;
            1: return (cnt[1] + 1) * t;
            2: return (op == 2'h0 ? 8 * (cnt[2] + 1) : 4096 * (cnt[op + 2] + 1)) * t;
            3: return (op == 2'h2 ? 8 * (cnt[6] + 1) : cnt[5] + 1) * t;
            default: return (cnt[7] + 1) * t;
        endcase
    endfunction : exp_len
    // Start stays high into the run, so a restart while busy must be ignored.
    task run(input logic [1:0] o, input logic s);
        int w;
        op = o;
        dsel = s;
        start = 1'b1;
        @(negedge clk);
        chk({pe, ge, be, busy}, {3'h4 >> o, 1'b1});
        repeat (2) @(negedge clk);
        start = 1'b0;
        for (w = 0; w < 20000 && done !== 1'b1; w++)
            @(negedge clk);
        if (w == 20000)
        begin
            miscompares++;
            results;
        end
        else
        begin
            @(negedge clk);
            chk(done, 1'b0);
            for (w = 0; w < 5; w++)
                chk(len[w], exp_len(w));
        end
    endtask : run
    initial
    begin
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        run(2'h0, 1'b0);
        cnt = '{8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff};
        // Different prescalers, so a wrong array select shows in every interval.
        psc = '{8'h01, 8'h00};
        run(2'h0, 1'b1);
        run(2'h2, 1'b0);
        op = 2'h3;
        start = 1'b1;
        @(negedge clk);
        chk(busy, 1'b0);
        start = 1'b0;
        @(negedge clk);
        for (int i = 0; i < 6; i++)
        begin
            psc[0] = 8'($random(seed) & 1);
            psc[1] = 8'($random(seed) & 3);
            foreach (cnt[k])
                cnt[k] = 8'($random(seed) & ((k == 3 || k == 4) ? 1 : 7));
            run(2'(i % 3), 1'(i % 3 == 0 ? $random(seed) : 0));
        end
        chk(bad, 1'b0);
        results;
    end
endmodule : fpet_timer_tb_top
`default_nettype wire
